/* design/gao_map.vh */
`ifndef GAO_MAP_VH
`define GAO_MAP_VH
// register indices, 4-bit address, 16-bit data
`define GAO_REG_CTRL 4'h0
`define GAO_REG_SP1 4'h1
`define GAO_REG_SP2 4'h2
`define GAO_REG_STATUS 4'h3
`define GAO_REG_IRQ_STAT 4'h4
`define GAO_REG_IRQ_MASK 4'h5
`define GAO_REG_LOOP 4'h6
// control fields
`define GAO_CTRL_DLY_EN 0
`define GAO_CTRL_MSEL_LO 1
`define GAO_CTRL_MSEL_HI 2
`define GAO_CTRL_MAINT 3
`define GAO_CTRL_INHIBIT 4
`define GAO_CTRL_TEST 5
`define GAO_CTRL_O2 6
`define GAO_CTRL_RESET 16'h0001
`define GAO_SP_RESET 12'hfff
// maintenance output selection
`define GAO_MSEL_2P5 2'h0
`define GAO_MSEL_4MA 2'h1
`define GAO_MSEL_HOLD 2'h2
`define GAO_MSEL_LIVE 2'h3
// loop levels in microamps
`define GAO_UA_ZERO 16'h0fa0
`define GAO_UA_2P5 16'h09c4
`define GAO_UA_FAULT 16'h01f4
`define GAO_UA_AIR 16'h43f8
`define GAO_UA_MAX 16'h55f0
`define GAO_UA_PER_COUNT 4'h4
// irq bits
`define GAO_IRQ_STAGE1 0
`define GAO_IRQ_STAGE2 1
`define GAO_IRQ_FAULT 2
`define GAO_IRQ_READY 3
// timing
`define GAO_CLK_KHZ 100000
`define GAO_ALARM_DELAY_MS 2000
`define GAO_INIT_MS 1000
`endif

/* design/gao_sync3.v */
`timescale 1ns/100ps
// three-stage pin synchroniser; output moves once stages two and three agree
module gao_sync3 (
   input wire clk_i,
   input wire reset_n_i,
   input wire pin_i,
   output reg level_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_o <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_o <= s3_q;
         end
      end
   end
endmodule

/* design/gao_core.v */
// What this block does
// - alarm at or above setpoint, auto clears
// - two stages, own setpoint, own red lamp
// - optional 2 s persistence delay, default on
// - contact follows alarm, self-releasing
// - green power lamp steady during detection
// - fault: yellow lamp and cause code shown
// - fault clearing reruns initialization
// - live 4-20 mA, clamped at 22 mA
// - maintenance output per selection setting
// - init/inhibit: 2.5 mA or 4 mA
// - comm option sends data and state flags
// - oxygen sensor: 17.4 mA replaces 4 mA
// - change to oxygen holds 4 mA
// - change from oxygen holds 17.4 mA
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "gao_map.vh"
module gao_core #(
   parameter integer ALARM_DELAY_CYC = `GAO_ALARM_DELAY_MS * `GAO_CLK_KHZ,
   parameter integer INIT_CYC = `GAO_INIT_MS * `GAO_CLK_KHZ
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   input wire [11:0] conc_i,
   input wire fault_i,
   input wire [3:0] fault_code_i,
   input wire confirm_key_i,
   output reg power_lamp_o,
   output reg first_stage_alarm_lamp_o,
   output reg second_stage_alarm_lamp_o,
   output reg fault_lamp_o,
   output reg [3:0] err_code_o,
   output reg alarm1_contact_o,
   output reg alarm2_contact_o,
   output reg [15:0] loop_ua_o,
   output reg [11:0] comm_conc_o,
   output reg [7:0] comm_flags_o,
   output reg irq_o
);
   localparam [2:0] ST_INIT = 3'h0;
   localparam [2:0] ST_DETECT = 3'h1;
   localparam [2:0] ST_MAINT = 3'h2;
   localparam [2:0] ST_FAULT = 3'h3;
   localparam [2:0] ST_SPEC = 3'h4;

   reg [15:0] ctrl_q;
   reg [11:0] sp1_q;
   reg [11:0] sp2_q;
   reg [3:0] irq_stat_q;
   reg [3:0] irq_mask_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg o2_q;
   reg [31:0] init_cnt_q;
   reg [31:0] dly1_q;
   reg [31:0] dly2_q;
   reg stage1_q;
   reg stage2_q;
   reg key_q;
   reg [15:0] loop_d;
   reg [3:0] irq_set;
   wire key_lvl;
   wire key_rise;
   wire [1:0] msel;
   wire fixed4_sel;
   wire [15:0] fixed4;
   wire [15:0] live;
   wire detecting;

   gao_sync3 u_key (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(confirm_key_i),
      .level_o(key_lvl)
   );

   ////////////////////////////////////////////////////////////////
   // loop scaling

   function [15:0] live_ua;
      input [11:0] c;
      reg [17:0] v;
      begin
         v = {6'h00, c} * {14'h0000, `GAO_UA_PER_COUNT} + {2'h0, `GAO_UA_ZERO};
         if (v > {2'h0, `GAO_UA_MAX}) begin
            live_ua = `GAO_UA_MAX;
         end else begin
            live_ua = v[15:0];
         end
      end
   endfunction

   assign key_rise = key_lvl & ~key_q;
   assign msel = ctrl_q[`GAO_CTRL_MSEL_HI:`GAO_CTRL_MSEL_LO];
   assign fixed4_sel = (msel != `GAO_MSEL_2P5);
   assign fixed4 = o2_q ? `GAO_UA_AIR : `GAO_UA_ZERO;
   assign live = live_ua(conc_i);
   assign detecting = (state_q == ST_DETECT) && !ctrl_q[`GAO_CTRL_INHIBIT];

   ////////////////////////////////////////////////////////////////
   // operating state

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_INIT: begin
            if (init_cnt_q >= INIT_CYC - 1) begin
               state_d = ctrl_q[`GAO_CTRL_MAINT] ? ST_MAINT : ST_DETECT;
            end
         end
         ST_DETECT: begin
            if (ctrl_q[`GAO_CTRL_O2] != o2_q) begin
               state_d = ST_SPEC;
            end else if (ctrl_q[`GAO_CTRL_MAINT]) begin
               state_d = ST_MAINT;
            end
         end
         ST_MAINT: begin
            if (ctrl_q[`GAO_CTRL_O2] != o2_q) begin
               state_d = ST_SPEC;
            end else if (!ctrl_q[`GAO_CTRL_MAINT]) begin
               state_d = ST_DETECT;
            end
         end
         ST_SPEC: begin
            if (key_rise) begin
               state_d = ST_INIT;
            end
         end
         ST_FAULT: begin
            if (!fault_i) begin
               state_d = ST_INIT;
            end
         end
         default: begin
            state_d = ST_INIT;
         end
      endcase
      if (fault_i) begin
         state_d = ST_FAULT;
      end
   end

   ////////////////////////////////////////////////////////////////
   // loop level

   always @* begin
      loop_d = loop_ua_o;
      case (state_q)
         ST_FAULT: begin
            loop_d = `GAO_UA_FAULT;
         end
         ST_INIT: begin
            loop_d = fixed4_sel ? fixed4 : `GAO_UA_2P5;
         end
         ST_SPEC: begin
            loop_d = fixed4;
         end
         ST_MAINT: begin
            case (msel)
               `GAO_MSEL_2P5: loop_d = `GAO_UA_2P5;
               `GAO_MSEL_4MA: loop_d = fixed4;
               `GAO_MSEL_HOLD: loop_d = loop_ua_o;
               default: loop_d = live;
            endcase
         end
         ST_DETECT: begin
            if (ctrl_q[`GAO_CTRL_INHIBIT]) begin
               loop_d = fixed4_sel ? fixed4 : `GAO_UA_2P5;
            end else begin
               loop_d = live;
            end
         end
         default: begin
            loop_d = fixed4;
         end
      endcase
   end

   always @* begin
      irq_set = 4'h0;
      irq_set[`GAO_IRQ_STAGE1] = detecting && (conc_i >= sp1_q) && !stage1_q &&
                                 (!ctrl_q[`GAO_CTRL_DLY_EN] || dly1_q >= ALARM_DELAY_CYC - 1);
      irq_set[`GAO_IRQ_STAGE2] = detecting && (conc_i >= sp2_q) && !stage2_q &&
                               (!ctrl_q[`GAO_CTRL_DLY_EN] || dly2_q >= ALARM_DELAY_CYC - 1);
      irq_set[`GAO_IRQ_FAULT] = (state_d == ST_FAULT) && (state_q != ST_FAULT);
      irq_set[`GAO_IRQ_READY] = (state_q == ST_INIT) && (state_d != ST_INIT);
   end

   ////////////////////////////////////////////////////////////////
   // sequential core

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_INIT;
         o2_q <= 1'b0;
         init_cnt_q <= 32'h0000_0000;
         dly1_q <= 32'h0000_0000;
         dly2_q <= 32'h0000_0000;
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
         key_q <= 1'b0;
         err_code_o <= 4'h0;
         loop_ua_o <= `GAO_UA_ZERO;
      end else begin
         state_q <= state_d;
         key_q <= key_lvl;
         loop_ua_o <= loop_d;
         if (state_q == ST_SPEC && key_rise) begin
            o2_q <= ctrl_q[`GAO_CTRL_O2];
         end
         if (state_q == ST_INIT && state_d == ST_INIT) begin
            init_cnt_q <= init_cnt_q + 32'h0000_0001;
         end else begin
            init_cnt_q <= 32'h0000_0000;
         end
         if (state_d == ST_FAULT && state_q != ST_FAULT) begin
            err_code_o <= fault_code_i;
         end
         // persistence counters restart whenever the level drops below
         if (detecting && conc_i >= sp1_q) begin
            if (dly1_q < ALARM_DELAY_CYC - 1) begin
               dly1_q <= dly1_q + 32'h0000_0001;
            end
         end else begin
            dly1_q <= 32'h0000_0000;
         end
         if (detecting && conc_i >= sp2_q) begin
            if (dly2_q < ALARM_DELAY_CYC - 1) begin
               dly2_q <= dly2_q + 32'h0000_0001;
            end
         end else begin
            dly2_q <= 32'h0000_0000;
         end
         if (!(detecting && conc_i >= sp1_q)) begin
            stage1_q <= 1'b0;
         end else if (irq_set[`GAO_IRQ_STAGE1]) begin
            stage1_q <= 1'b1;
         end
         if (!(detecting && conc_i >= sp2_q)) begin
            stage2_q <= 1'b0;
         end else if (irq_set[`GAO_IRQ_STAGE2]) begin
            stage2_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // indicators, contacts, comm option

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         power_lamp_o <= 1'b0;
         first_stage_alarm_lamp_o <= 1'b0;
         second_stage_alarm_lamp_o <= 1'b0;
         fault_lamp_o <= 1'b0;
         alarm1_contact_o <= 1'b0;
         alarm2_contact_o <= 1'b0;
         comm_conc_o <= 12'h000;
         comm_flags_o <= 8'h00;
      end else begin
         power_lamp_o <= 1'b1;
         first_stage_alarm_lamp_o <= stage1_q;
         second_stage_alarm_lamp_o <= stage2_q;
         fault_lamp_o <= (state_q == ST_FAULT);
         alarm1_contact_o <= stage1_q;
         alarm2_contact_o <= stage2_q;
         // fault frames carry no concentration
         comm_conc_o <= (state_q == ST_FAULT) ? 12'h000 : conc_i;
         comm_flags_o <= {1'b1,
                          ctrl_q[`GAO_CTRL_INHIBIT] && state_q == ST_DETECT,
                          state_q == ST_FAULT,
                          state_q == ST_MAINT && ctrl_q[`GAO_CTRL_TEST],
                          state_q == ST_MAINT || (ctrl_q[`GAO_CTRL_INHIBIT] && state_q == ST_DETECT),
                          state_q == ST_INIT || state_q == ST_SPEC,
                          stage2_q,
                          stage1_q};
      end
   end

   ////////////////////////////////////////////////////////////////
   // register port and interrupt

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= `GAO_CTRL_RESET;
         sp1_q <= `GAO_SP_RESET;
         sp2_q <= `GAO_SP_RESET;
         irq_stat_q <= 4'h0;
         irq_mask_q <= 4'h0;
         rdata_o <= 16'h0000;
         irq_o <= 1'b0;
      end else begin
         if (wr_i && addr_i == `GAO_REG_CTRL) begin
            ctrl_q <= {9'h000, wdata_i[6:0]};
         end
         if (wr_i && addr_i == `GAO_REG_SP1) begin
            sp1_q <= wdata_i[11:0];
         end
         if (wr_i && addr_i == `GAO_REG_SP2) begin
            sp2_q <= wdata_i[11:0];
         end
         if (wr_i && addr_i == `GAO_REG_IRQ_MASK) begin
            irq_mask_q <= wdata_i[3:0];
         end
         // a new event in the clearing cycle survives the write
         if (wr_i && addr_i == `GAO_REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wdata_i[3:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         irq_o <= |((irq_stat_q | irq_set) & irq_mask_q);
         if (rd_i) begin
            case (addr_i)
               `GAO_REG_CTRL: rdata_o <= ctrl_q;
               `GAO_REG_SP1: rdata_o <= {4'h0, sp1_q};
               `GAO_REG_SP2: rdata_o <= {4'h0, sp2_q};
               `GAO_REG_STATUS: rdata_o <= {4'h0, err_code_o, o2_q, 2'h0, stage2_q, stage1_q, state_q};
               `GAO_REG_IRQ_STAT: rdata_o <= {12'h000, irq_stat_q};
               `GAO_REG_IRQ_MASK: rdata_o <= {12'h000, irq_mask_q};
               `GAO_REG_LOOP: rdata_o <= loop_ua_o;
               default: rdata_o <= 16'h0000;
            endcase
         end else begin
            rdata_o <= 16'h0000;
         end
      end
   end
endmodule

/* tb/gao_core_props.sv */
`timescale 1ns/100ps
module gao_core_props (
   input wire clk_i,
   input wire reset_n_i,
   input wire fault_i,
   input wire power_lamp_o,
   input wire first_stage_alarm_lamp_o,
   input wire second_stage_alarm_lamp_o,
   input wire fault_lamp_o,
   input wire [3:0] err_code_o,
   input wire alarm1_contact_o,
   input wire alarm2_contact_o,
   input wire [15:0] loop_ua_o,
   input wire [11:0] comm_conc_o,
   input wire [7:0] comm_flags_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_power_steady: assert property ($past(reset_n_i) |-> power_lamp_o)
      else $error("power lamp dark");
   a_signal_on: assert property ($past(reset_n_i) |-> comm_flags_o[7])
      else $error("signal flag low");
   a_loop_ceiling: assert property (loop_ua_o <= 16'h55f0)
      else $error("loop above ceiling");
   a_fault_loop: assert property (fault_lamp_o |-> loop_ua_o == 16'h01f4)
      else $error("fault loop level wrong");
   a_fault_flag: assert property (fault_lamp_o |-> comm_flags_o[5] && comm_conc_o == 12'h000)
      else $error("fault flag or data wrong");
   a_contact_one: assert property (alarm1_contact_o == first_stage_alarm_lamp_o)
      else $error("contact one mismatch");
   a_contact_two: assert property (alarm2_contact_o == second_stage_alarm_lamp_o)
      else $error("contact two mismatch");
   a_fault_entry: assert property ($rose(fault_i) |-> ##[1:4] fault_lamp_o)
      else $error("fault not entered");
   a_code_held: assert property (fault_lamp_o && $past(fault_lamp_o) |-> $stable(err_code_o))
      else $error("fault code moved");
   a_fault_restart: assert property ($fell(fault_lamp_o) |-> ##[0:1] comm_flags_o[2])
      else $error("no restart after fault");
endmodule
bind gao_core gao_core_props u_props (.clk_i, .reset_n_i, .fault_i, .power_lamp_o,
   .first_stage_alarm_lamp_o, .second_stage_alarm_lamp_o, .fault_lamp_o, .err_code_o,
   .alarm1_contact_o, .alarm2_contact_o, .loop_ua_o, .comm_conc_o, .comm_flags_o);

/* tb/gao_panel.sv */
`timescale 1ns/100ps
// receiving panel: decodes the loop level as a listener would
module gao_panel (
   input wire clk_i,
   input wire [15:0] loop_ua_i,
   input wire [7:0] flags_i,
   output logic fault_seen_o,
   output logic over_o
);
   always @(posedge clk_i) begin
      fault_seen_o <= loop_ua_i < 16'h0fa0 && flags_i[5];
      over_o <= loop_ua_i > 16'h55f0;
   end
endmodule

/* tb/gao_core_tb.sv */
`timescale 1ns/100ps
`include "gao_map.vh"
module gao_core_tb;
   logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, fault_i = 0, confirm_key_i = 0, snap = 0, rd_d = 0;
   logic [3:0] addr_i = 0, fault_code_i = 0, fc;
   logic [15:0] wdata_i = 0;
   logic [11:0] conc_i = 0, c;
   wire [15:0] rdata_o, loop_ua_o;
   wire [11:0] comm_conc_o;
   wire [7:0] comm_flags_o;
   wire [3:0] err_code_o;
   wire pw, a1, a2, fl, c1, c2, irq_o, fs, ov;
   typedef struct {logic [2:0] k; logic [15:0] e;} note_t;
   note_t q[$];
   note_t n;
   int n_fail = 0, compares = 0;
   always #5 clk_i = ~clk_i;
   gao_core #(.ALARM_DELAY_CYC(20), .INIT_CYC(10)) uut (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .conc_i, .fault_i, .fault_code_i, .confirm_key_i, .power_lamp_o(pw),
      .first_stage_alarm_lamp_o(a1), .second_stage_alarm_lamp_o(a2), .fault_lamp_o(fl), .err_code_o,
      .alarm1_contact_o(c1), .alarm2_contact_o(c2), .loop_ua_o, .comm_conc_o, .comm_flags_o, .irq_o);
   gao_panel u_panel (.clk_i, .loop_ua_i(loop_ua_o), .flags_i(comm_flags_o), .fault_seen_o(fs), .over_o(ov));
   ////////////////////////////////////////////////////////////
   task automatic check(string nm, logic [15:0] s, logic [15:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task report_and_stop;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one note per read or snapshot, taken when the result stands
   always @(posedge clk_i) begin
      rd_d <= rd_i;
      if ((rd_d || snap) && q.size() > 0) begin
         n = q.pop_front();
         case (n.k)
            0: check("rdata", rdata_o, n.e);
            1: check("loop", loop_ua_o, n.e);
            2: check("lamps", {8'h0, ov, fs, irq_o, a1, a2, fl, c1, c2}, n.e);
            4: check("conc", {4'h0, comm_conc_o}, n.e);
            default: check("flags", {err_code_o, 3'h0, pw, comm_flags_o}, n.e);
         endcase
      end
   end
   task cyc(int k);
      repeat (k) @(posedge clk_i);
   endtask
   task wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1;
      @(posedge clk_i);
      wr_i <= 0;
   endtask
   task rd(logic [3:0] a, logic [15:0] e);
      q.push_back('{3'd0, e});
      @(posedge clk_i);
      addr_i <= a; rd_i <= 1;
      @(posedge clk_i);
      rd_i <= 0;
   endtask
   task ex(logic [2:0] k, logic [15:0] e);
      q.push_back('{k, e});
      @(posedge clk_i);
      snap <= 1;
      @(posedge clk_i);
      snap <= 0;
   endtask
   task confirm;
      @(posedge clk_i);
      confirm_key_i <= 1;
      cyc(3);
      confirm_key_i <= 0;
      cyc(20);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      report_and_stop;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      c = 12'($urandom(62600));
      c = 12'($urandom_range(998, 0));
      cyc(2);
      reset_n_i <= 1;
      // init is short here, so look at it before the register reads
      ex(1, `GAO_UA_2P5);
      ex(3, 16'h0184);
      rd(`GAO_REG_CTRL, `GAO_CTRL_RESET);
      rd(`GAO_REG_SP1, 16'h0fff);
      rd(`GAO_REG_SP2, 16'h0fff);
      wr(4'h7, 16'hffff);
      rd(4'h7, 16'h0000);
      cyc(12);
      rd(`GAO_REG_IRQ_STAT, 16'h0008);
      rd(`GAO_REG_STATUS, 16'h0001);
      $display("test reset done");
      conc_i <= c;
      cyc(3);
      ex(1, 16'd4000 + 16'd4 * c);
      conc_i <= 12'hfff;
      cyc(3);
      ex(1, 16'd20380);
      conc_i <= 0;
      wr(`GAO_REG_SP1, 16'd1000);
      wr(`GAO_REG_SP2, 16'd2000);
      wr(`GAO_REG_IRQ_MASK, 16'h0001);
      wr(`GAO_REG_IRQ_STAT, 16'h000f);
      wr(`GAO_REG_CTRL, 16'h0000);
      conc_i <= 12'd1000;
      cyc(4);
      ex(2, 16'h0032);
      ex(3, 16'h0181);
      rd(`GAO_REG_STATUS, 16'h0009);
      conc_i <= 12'd2000;
      cyc(4);
      ex(2, 16'h003b);
      rd(`GAO_REG_STATUS, 16'h0019);
      conc_i <= 12'd999;
      cyc(4);
      ex(2, 16'h0020);
      wr(`GAO_REG_IRQ_STAT, 16'h0003);
      cyc(2);
      ex(2, 16'h0000);
      wr(`GAO_REG_CTRL, 16'h0001);
      conc_i <= 12'd2000;
      cyc(10);
      ex(2, 16'h0000);
      cyc(15);
      ex(2, 16'h003b);
      conc_i <= 0;
      wr(`GAO_REG_IRQ_MASK, 16'h0000);
      cyc(4);
      ex(2, 16'h0000);
      $display("test alarm done");
      for (int s = 0; s < 4; s++) begin
         conc_i <= c;
         wr(`GAO_REG_CTRL, 16'h0000);
         cyc(3);
         wr(`GAO_REG_CTRL, 16'h0028 | 16'(s << 1));
         cyc(3);
         conc_i <= c + 12'd1;
         cyc(3);
         case (s)
            0: ex(1, `GAO_UA_2P5);
            1: ex(1, `GAO_UA_ZERO);
            2: ex(1, 16'd4000 + 16'd4 * c);
            default: ex(1, 16'd4004 + 16'd4 * c);
         endcase
      end
      ex(3, 16'h0198);
      ex(4, {4'h0, c + 12'd1});
      wr(`GAO_REG_CTRL, 16'h0010);
      cyc(3);
      ex(1, `GAO_UA_2P5);
      wr(`GAO_REG_CTRL, 16'h0014);
      cyc(3);
      ex(1, `GAO_UA_ZERO);
      $display("test output levels done");
      wr(`GAO_REG_CTRL, 16'h0000);
      fc = 4'($urandom_range(15, 1));
      fault_code_i <= fc;
      fault_i <= 1;
      cyc(4);
      ex(1, `GAO_UA_FAULT);
      ex(2, 16'h0044);
      ex(3, {fc, 12'h1a0});
      rd(`GAO_REG_LOOP, `GAO_UA_FAULT);
      fault_i <= 0;
      cyc(2);
      ex(3, {fc, 12'h184});
      cyc(12);
      rd(`GAO_REG_STATUS, {4'h0, fc, 8'h01});
      rd(`GAO_REG_IRQ_STAT, 16'h000f);
      $display("test fault done");
      wr(`GAO_REG_CTRL, 16'h0040);
      cyc(3);
      ex(1, `GAO_UA_ZERO);
      confirm;
      rd(`GAO_REG_STATUS, {4'h0, fc, 8'h81});
      wr(`GAO_REG_CTRL, 16'h0052);
      cyc(3);
      ex(1, `GAO_UA_AIR);
      wr(`GAO_REG_CTRL, 16'h0000);
      cyc(3);
      ex(1, `GAO_UA_AIR);
      confirm;
      rd(`GAO_REG_STATUS, {4'h0, fc, 8'h01});
      cyc(3);
      $display("test sensor change done");
      report_and_stop;
   end
endmodule
